// *** rtl/mdl_pkg.sv ***
// Purpose: Shared constants for the microcode download command block
// Assumes: Taskfile bytes are presented alongside a command strobe
// Notes: Status and error layouts are fixed byte images

package mdl_pkg;

    // Command and subcommand codes
    localparam logic [7:0] MDL_CMD_DOWNLOAD = 8'h92;
    localparam logic [7:0] MDL_SUB_OFFSETS = 8'h03;
    localparam logic [7:0] MDL_SUB_WHOLE = 8'h07;

    // Sector geometry: 512 bytes carried as 16-bit data words
    localparam int MDL_SECTOR_BYTES = 512;
    localparam int MDL_WORD_BYTES = 2;
    localparam int MDL_WORDS_PER_SECTOR = MDL_SECTOR_BYTES / MDL_WORD_BYTES;
    localparam int MDL_WORD_SHIFT = 8;

    // Error register bit positions
    localparam int MDL_ERR_UNC_POS = 6;
    localparam int MDL_ERR_ABT_POS = 2;

    // Status register bit positions
    localparam int MDL_ST_BSY_POS = 7;
    localparam int MDL_ST_RDY_POS = 6;
    localparam int MDL_ST_DF_POS = 5;
    localparam int MDL_ST_DSC_POS = 4;
    localparam int MDL_ST_DRQ_POS = 3;
    localparam int MDL_ST_COR_POS = 2;
    localparam int MDL_ST_ERR_POS = 0;

    // Values after reset
    localparam logic [7:0] MDL_ERR_RESET = 8'h00;
    localparam logic [7:0] MDL_STATUS_RESET = 8'h50;

    // Command sequencer states
    typedef enum logic [2:0] {
        MDL_IDLE = 3'b000,
        MDL_XFER = 3'b001,
        MDL_VERIFY = 3'b010,
        MDL_SAVE = 3'b011,
        MDL_RELOAD = 3'b100,
        MDL_DONE = 3'b101
    } mdl_state_t;

endpackage

// *** rtl/mdl_seg_track.sv ***
// Purpose: Tracks the expected next offset of an offset-mode download
// Assumes: One check pulse per accepted segment command
// Notes: Clearing wins only when no new segment is recorded

`timescale 1ns/1ps

module mdl_seg_track (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // Segment being checked
    input wire logic [15:0] offset_in,
    input wire logic [15:0] count_in,
    input wire logic record_in,
    input wire logic clear_in,
    // Tracker state
    output logic in_order_out,
    output logic active_out
);
    import mdl_pkg::*;

    logic [15:0] next_q;
    logic [15:0] next_d;
    logic active_q;

    // First segment must start at zero, later ones where the last ended
    assign in_order_out = active_q ? (offset_in == next_q) : (offset_in == 16'h0000);
    assign next_d = offset_in + count_in;
    assign active_out = active_q;

    // Recording beats clearing so a fresh segment is never lost
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            next_q <= 16'h0000;
            active_q <= 1'b0;
        end else if (record_in) begin
            next_q <= next_d;
            active_q <= 1'b1;
        end else if (clear_in) begin
            next_q <= 16'h0000;
            active_q <= 1'b0;
        end
    end

endmodule // mdl_seg_track

// *** rtl/mdl_download_cmd.sv ***
// Purpose: Device-side handler for the download-microcode command
// Assumes: Host loads taskfile bytes before the command strobe
// Notes: Verification, saving and reload are done by firmware helpers
//
// Summary of operation
// - Command code 92h selects this handler
// - Feature 03h offsets, 07h whole, others reserved
// - Length: sector number high, count low
// - Zero length transfers no data
// - Abort on bad subcommand or security lock
// - Uncorrectable error only on failed requested reload
// - Spin down after successful reload if spin-up disabled
// - Offset from cylinder bytes, offset mode only
// - Offset counts 512-byte units into image
// - Abort and discard on offset sequence gap
// - Final segment: verify then save image
// - New firmware takes effect after last segment
// - Other command discards partial image
// - Reset drops partial image first
// - Completion status: ready, seek complete, error valid

`timescale 1ns/1ps

module mdl_download_cmd #(
    parameter int ADDR_W = 24
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic soft_reset_in,
    // Taskfile written by the host
    input wire logic cmd_wr_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [7:0] feature_in,
    input wire logic [7:0] sector_count_in,
    input wire logic [7:0] sector_number_in,
    input wire logic [7:0] cylinder_low_in,
    input wire logic [7:0] cylinder_high_in,
    // Device conditions
    input wire logic security_locked_in,
    input wire logic spinup_disabled_in,
    input wire logic [15:0] image_sectors_in,
    // Host data stream
    input wire logic data_valid_in,
    input wire logic [15:0] data_in,
    output logic data_ready_out,
    // Image store
    output logic img_wr_out,
    output logic [ADDR_W-1:0] img_addr_out,
    output logic [15:0] img_data_out,
    output logic discard_out,
    // Verification and saving
    output logic verify_start_out,
    input wire logic verify_done_in,
    input wire logic verify_ok_in,
    output logic save_start_out,
    input wire logic save_done_in,
    // Reload of new firmware
    input wire logic reload_req_in,
    output logic reload_start_out,
    input wire logic reload_done_in,
    input wire logic reload_fail_in,
    output logic spin_down_out,
    // Completion registers
    output logic [7:0] command_error_flags_out,
    output logic [7:0] command_completion_flags_out,
    output logic cmd_done_out
);
    import mdl_pkg::*;

    mdl_state_t state_q;
    mdl_state_t state_d;

    logic [15:0] seg_offset_q;
    logic [15:0] seg_count_q;
    logic offset_mode_q;
    logic last_seg_q;
    logic [ADDR_W-1:0] words_left_q;
    logic [ADDR_W-1:0] addr_q;
    logic unc_q;
    logic abt_q;
    logic data_ready_q;
    logic img_wr_q;
    logic [ADDR_W-1:0] img_addr_q;
    logic [15:0] img_data_q;
    logic discard_q;
    logic verify_start_q;
    logic save_start_q;
    logic reload_start_q;
    logic spin_down_q;
    logic cmd_done_q;
    logic [7:0] err_q;
    logic [7:0] status_q;

    // Subcommand decode, shared by the start checks
    function automatic logic sub_valid(input logic [7:0] sub);
        return (sub == MDL_SUB_OFFSETS) || (sub == MDL_SUB_WHOLE);
    endfunction

    // Taskfile decode
    wire is_download = cmd_wr_in && (cmd_code_in == MDL_CMD_DOWNLOAD);
    wire other_cmd = cmd_wr_in && (cmd_code_in != MDL_CMD_DOWNLOAD);
    wire sub_ok = sub_valid(feature_in);
    wire sub_offsets = (feature_in == MDL_SUB_OFFSETS);
    wire [15:0] xfer_sectors = {sector_number_in, sector_count_in};
    wire zero_len = (xfer_sectors == 16'h0000);
    wire [15:0] req_offset = sub_offsets ? {cylinder_high_in, cylinder_low_in} : 16'h0000;
    wire start_abort = !sub_ok || security_locked_in;

    // Offset-mode sequence check
    wire seq_in_order;
    wire seq_active;
    wire seq_record = (state_q == MDL_IDLE) && is_download && !start_abort
                      && sub_offsets && seq_in_order && !zero_len;
    wire seq_gap = (state_q == MDL_IDLE) && is_download && !start_abort
                   && sub_offsets && !seq_in_order;
    // Wraps at 16 bits
    wire [15:0] seg_end = req_offset + xfer_sectors;
    wire is_last = !sub_offsets || (seg_end >= image_sectors_in);

    // Partial image dropped on foreign command, soft reset or offset sequence gap
    wire drop_partial = (other_cmd && seq_active) || (soft_reset_in && seq_active)
                        || seq_gap;
    wire seq_clear = drop_partial || (state_q == MDL_SAVE && save_done_in)
                     || (state_q == MDL_VERIFY && verify_done_in && !verify_ok_in)
                     || (is_download && start_abort);

    // Transfer cut short
    wire xfer_cut = (state_q == MDL_XFER) && (soft_reset_in || other_cmd);

    mdl_seg_track mdl_seg_track_i (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .offset_in(req_offset),
        .count_in(xfer_sectors),
        .record_in(seq_record),
        .clear_in(seq_clear),
        .in_order_out(seq_in_order),
        .active_out(seq_active)
    );

    // Data path decode
    wire word_take = (state_q == MDL_XFER) && data_valid_in && data_ready_q;
    wire last_word = word_take && (words_left_q == ADDR_W'(1));
    wire [ADDR_W-1:0] start_words = ADDR_W'(xfer_sectors) << MDL_WORD_SHIFT;
    wire [ADDR_W-1:0] start_addr = ADDR_W'(req_offset) << MDL_WORD_SHIFT;
    wire good_start = is_download && !start_abort && !seq_gap;

    // Next state of the command sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            MDL_IDLE: begin
                if (good_start && !zero_len) begin
                    state_d = MDL_XFER;
                end else if (is_download) begin
                    state_d = MDL_DONE;
                end
            end
            MDL_XFER: begin
                if (xfer_cut) begin
                    state_d = MDL_IDLE;
                end else if (last_word) begin
                    state_d = last_seg_q ? MDL_VERIFY : MDL_DONE;
                end
            end
            MDL_VERIFY: begin
                if (soft_reset_in) begin
                    state_d = MDL_IDLE;
                end else if (verify_done_in) begin
                    state_d = verify_ok_in ? MDL_SAVE : MDL_DONE;
                end
            end
            // Save runs to its end
            MDL_SAVE: begin
                if (save_done_in) begin
                    state_d = reload_req_in ? MDL_RELOAD : MDL_DONE;
                end
            end
            MDL_RELOAD: begin
                if (reload_done_in) begin
                    state_d = MDL_DONE;
                end
            end
            MDL_DONE: begin
                state_d = MDL_IDLE;
            end
            default: begin
                state_d = MDL_IDLE;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= MDL_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Segment parameters captured when the command is accepted
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            seg_offset_q <= 16'h0000;
            seg_count_q <= 16'h0000;
            offset_mode_q <= 1'b0;
            last_seg_q <= 1'b0;
        end else if (state_q == MDL_IDLE && good_start) begin
            seg_offset_q <= req_offset;
            seg_count_q <= xfer_sectors;
            offset_mode_q <= sub_offsets;
            last_seg_q <= is_last;
        end
    end

    // Word counter and image address
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            words_left_q <= '0;
            addr_q <= '0;
        end else if (state_q == MDL_IDLE && good_start) begin
            words_left_q <= start_words;
            addr_q <= start_addr;
        end else if (word_take) begin
            words_left_q <= words_left_q - ADDR_W'(1);
            addr_q <= addr_q + ADDR_W'(1);
        end
    end

    // Ready drops on the final word so no extra data is taken
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            data_ready_q <= 1'b0;
        end else begin
            data_ready_q <= (state_d == MDL_XFER) && !last_word;
        end
    end

    // Image write port, one word per accepted beat
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            img_wr_q <= 1'b0;
            img_addr_q <= '0;
            img_data_q <= 16'h0000;
        end else begin
            img_wr_q <= word_take;
            if (word_take) begin
                img_addr_q <= addr_q;
                img_data_q <= data_in;
            end
        end
    end

    // Discard pulse also covers a failed verification
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            discard_q <= 1'b0;
        end else begin
            discard_q <= drop_partial
                         || (state_q == MDL_VERIFY && verify_done_in && !verify_ok_in)
                         || xfer_cut;
        end
    end

    // Helper strobes, each one cycle wide
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            verify_start_q <= 1'b0;
            save_start_q <= 1'b0;
            reload_start_q <= 1'b0;
            spin_down_q <= 1'b0;
        end else begin
            verify_start_q <= (state_q == MDL_XFER) && (state_d == MDL_VERIFY);
            save_start_q <= (state_q == MDL_VERIFY) && (state_d == MDL_SAVE);
            reload_start_q <= (state_q == MDL_SAVE) && (state_d == MDL_RELOAD);
            spin_down_q <= (state_q == MDL_RELOAD) && reload_done_in && !reload_fail_in
                           && spinup_disabled_in;
        end
    end

    // Error bits, cleared at the start of each download command
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            abt_q <= 1'b0;
            unc_q <= 1'b0;
        end else if (state_q == MDL_IDLE && is_download) begin
            abt_q <= start_abort || seq_gap;
            unc_q <= 1'b0;
        end else begin
            if (state_q == MDL_VERIFY && verify_done_in && !verify_ok_in) begin
                abt_q <= 1'b1;
            end
            if (state_q == MDL_RELOAD && reload_done_in && reload_fail_in) begin
                unc_q <= 1'b1;
            end
        end
    end

    // Error register image; unused bits stay zero
    wire [7:0] err_img = (8'(unc_q) << MDL_ERR_UNC_POS)
                         | (8'(abt_q) << MDL_ERR_ABT_POS);
    // Done reads as idle
    wire busy = (state_d != MDL_IDLE) && (state_d != MDL_DONE);
    wire data_request_bit = (state_d == MDL_XFER);
    wire [7:0] st_img = (8'(busy) << MDL_ST_BSY_POS)
                        | (8'(!busy) << MDL_ST_RDY_POS)
                        | (8'(1'b1) << MDL_ST_DSC_POS)
                        | (8'(data_request_bit) << MDL_ST_DRQ_POS)
                        | (8'(|err_img) << MDL_ST_ERR_POS);

    // Completion registers follow the sequencer; fault and corrected stay 0
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            err_q <= MDL_ERR_RESET;
            status_q <= MDL_STATUS_RESET;
            cmd_done_q <= 1'b0;
        end else begin
            err_q <= err_img;
            status_q <= st_img;
            cmd_done_q <= (state_q == MDL_DONE);
        end
    end

    // Outputs straight from flip-flops
    assign data_ready_out = data_ready_q;
    assign img_wr_out = img_wr_q;
    assign img_addr_out = img_addr_q;
    assign img_data_out = img_data_q;
    assign discard_out = discard_q;
    assign verify_start_out = verify_start_q;
    assign save_start_out = save_start_q;
    assign reload_start_out = reload_start_q;
    assign spin_down_out = spin_down_q;
    assign command_error_flags_out = err_q;
    assign command_completion_flags_out = status_q;
    assign cmd_done_out = cmd_done_q;

endmodule // mdl_download_cmd

// *** verif/mdl_download_cmd_sva.sv ***
// Purpose: Port checker for the download-microcode handler
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Reload helper flag clears at every command write
`timescale 1ns/1ps
module mdl_download_cmd_sva (
    // Clock, reset and taskfile
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic cmd_wr_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [7:0] feature_in,
    input wire logic [7:0] sector_count_in,
    input wire logic [7:0] sector_number_in,
    input wire logic security_locked_in,
    input wire logic spinup_disabled_in,
    // Data and helper handshakes
    input wire logic data_valid_in,
    input wire logic data_ready_out,
    input wire logic img_wr_out,
    input wire logic verify_done_in,
    input wire logic verify_ok_in,
    input wire logic save_start_out,
    input wire logic save_done_in,
    input wire logic reload_req_in,
    input wire logic reload_start_out,
    input wire logic spin_down_out,
    // Completion
    input wire logic [7:0] command_error_flags_out,
    input wire logic [7:0] command_completion_flags_out,
    input wire logic cmd_done_out
);
    import mdl_pkg::*;
    logic rl_q;
    // Command write while idle
    wire dl_w = cmd_wr_in && !command_completion_flags_out[7];
    wire hit_w = dl_w && cmd_code_in == MDL_CMD_DOWNLOAD;
    wire bad_w = feature_in != MDL_SUB_OFFSETS && feature_in != MDL_SUB_WHOLE;
    wire rej_w = bad_w || security_locked_in;
    wire zero_w = {sector_number_in, sector_count_in} == 16'h0000;
    wire whole_w = hit_w && !security_locked_in && feature_in == MDL_SUB_WHOLE;
    // Ties an uncorrectable flag to a reload
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rl_q <= 1'b0;
        end else begin
            rl_q <= reload_start_out || (rl_q && !cmd_wr_in);
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    property p_start; whole_w && !zero_w |=> data_ready_out; endproperty
    a_start: assert property (p_start) else $error("transfer not opened");
    property p_other; dl_w && cmd_code_in != MDL_CMD_DOWNLOAD |=> !data_ready_out [*2]; endproperty
    a_other: assert property (p_other) else $error("foreign code opened transfer");
    property p_abort;
        hit_w && rej_w |=> ##1 command_error_flags_out[2] && cmd_done_out;
    endproperty
    a_abort: assert property (p_abort) else $error("abort missing");
    property p_zero;
        whole_w && zero_w |=> !data_ready_out ##1 cmd_done_out && command_error_flags_out == 8'h00;
    endproperty
    a_zero: assert property (p_zero) else $error("zero length wrong");
    property p_bits; (command_error_flags_out & 8'hbb) == 8'h00; endproperty
    a_bits: assert property (p_bits) else $error("stray error bit");
    property p_stat;
        cmd_done_out |-> (command_completion_flags_out & 8'hfe) == 8'h50
            && command_completion_flags_out[0] == |command_error_flags_out;
    endproperty
    a_stat: assert property (p_stat) else $error("completion status wrong");
    property p_unc; cmd_done_out && command_error_flags_out[6] |-> rl_q; endproperty
    a_unc: assert property (p_unc) else $error("uncorrectable without reload");
    property p_spin; spin_down_out |-> rl_q && spinup_disabled_in; endproperty
    a_spin: assert property (p_spin) else $error("spin down unexpected");
    property p_save; save_start_out |-> $past(verify_done_in && verify_ok_in); endproperty
    a_save: assert property (p_save) else $error("save without verify");
    property p_rl; reload_start_out |-> $past(save_done_in && reload_req_in); endproperty
    a_rl: assert property (p_rl) else $error("reload without request");
    property p_wr; img_wr_out |-> $past(data_valid_in && data_ready_out); endproperty
    a_wr: assert property (p_wr) else $error("word stored untaken");
    // Main scenarios reached
    c_abort: cover property (hit_w && rej_w);
    c_reload: cover property (reload_start_out);
    c_spin: cover property (spin_down_out);
endmodule // mdl_download_cmd_sva
bind mdl_download_cmd mdl_download_cmd_sva mdl_download_cmd_sva_i (.*);

// *** verif/mdl_fw_model.sv ***
// Purpose: Firmware helper stand-in for verify, save and reload
// Assumes: At most one helper step outstanding
// Notes: Outcome levels inverted outside the answer cycle
`timescale 1ns/1ps
module mdl_fw_model (
    // Clock and requests
    input wire logic clk_sys_in,
    input wire logic verify_start_in,
    input wire logic save_start_in,
    input wire logic reload_start_in,
    // Behaviour set by the bench
    input wire logic [3:0] lag_in,
    input wire logic ok_in,
    input wire logic fail_in,
    // Answers
    output logic verify_done_out,
    output logic verify_ok_out,
    output logic save_done_out,
    output logic reload_done_out,
    output logic reload_fail_out
);
    logic [2:0] k;
    // Starts seen mid-cycle so registered pulses are never raced
    initial begin
        {verify_done_out, verify_ok_out, save_done_out, reload_done_out, reload_fail_out} = '0;
        forever begin
            @(negedge clk_sys_in);
            k = {verify_start_in, save_start_in, reload_start_in};
            if (k != 3'h0) begin
                repeat (lag_in + 1) @(posedge clk_sys_in);
                #1;
                {verify_done_out, save_done_out, reload_done_out} = k;
                {verify_ok_out, reload_fail_out} = {ok_in, fail_in};
                @(posedge clk_sys_in);
                #1;
                {verify_done_out, save_done_out, reload_done_out} = 3'h0;
                {verify_ok_out, reload_fail_out} = {!ok_in, !fail_in};
            end
        end
    end
endmodule // mdl_fw_model

// *** verif/mdl_download_cmd_tb_top.sv ***
// Purpose: Self-checking bench for the download-microcode handler
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Stimulus from a fixed-seed shift register
`timescale 1ns/1ps
module mdl_download_cmd_tb_top;
    import mdl_pkg::*;
    logic clk_sys_in = '0, nrst_in = '0, soft_reset_in = '0, cmd_wr_in = '0, data_valid_in = '0;
    logic security_locked_in = '0, spinup_disabled_in = '0, reload_req_in = '0, ok = '1, fail = '0;
    logic [7:0] cmd_code_in = '0, feature_in = '0, sector_count_in = '0, sector_number_in = '0;
    logic [7:0] cylinder_low_in = '0, cylinder_high_in = '0, f;
    logic [7:0] command_error_flags_out, command_completion_flags_out;
    logic [15:0] image_sectors_in = 16'h0001, data_in = '0, img_data_out;
    logic [23:0] img_addr_out, wa = '0;
    logic [3:0] lag = '0;
    logic [31:0] lf = 32'hd14f;
    logic [39:0] sb[$];
    logic data_ready_out, img_wr_out, discard_out, verify_start_out, save_start_out;
    logic reload_start_out, spin_down_out, cmd_done_out, verify_done_in, verify_ok_in;
    logic save_done_in, reload_done_in, reload_fail_in;
    int fails = 0, samples_checked = 0, disc_n = 0, spin_n = 0, rl_n = 0, d;
    mdl_download_cmd mdl_download_cmd_i (.*);
    mdl_fw_model mdl_fw_model_i (.clk_sys_in, .verify_start_in(verify_start_out),
        .save_start_in(save_start_out), .reload_start_in(reload_start_out), .lag_in(lag),
        .ok_in(ok), .fail_in(fail), .verify_done_out(verify_done_in),
        .verify_ok_out(verify_ok_in), .save_done_out(save_done_in),
        .reload_done_out(reload_done_in), .reload_fail_out(reload_fail_in));
    // 200 MHz system clock
    always #2.5 clk_sys_in = ~clk_sys_in;
    function automatic logic [15:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf[15:0];
    endfunction
    // Completion status follows the error byte
    function automatic logic [7:0] st_exp(input logic [7:0] e);
        return {7'h28, |e};
    endfunction
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    // Taskfile loaded with a one-cycle strobe
    task automatic cmd(input logic [7:0] c, input logic [7:0] s, input logic [15:0] n,
            input logic [15:0] o);
        {cmd_code_in, feature_in} = {c, s};
        {sector_number_in, sector_count_in, cylinder_high_in, cylinder_low_in} = {n, o};
        wa = (s == MDL_SUB_OFFSETS) ? {o, 8'h00} : 24'h000000;
        cmd_wr_in = 1'b1;
        tick();
        cmd_wr_in = 1'b0;
    endtask
    // Words held until taken
    task automatic send(input int w);
        int i = 0;
        int k;
        logic tk;
        data_valid_in = 1'b1;
        data_in = rnd();
        for (k = 0; k < w * 4 + 64 && i < w; k++) begin
            @(negedge clk_sys_in);
            tk = data_ready_out;
            tick();
            if (tk) begin
                i++;
                data_in = rnd();
            end
        end
        data_valid_in = 1'b0;
        if (i < w) begin
            fails++;
            finish_test();
        end
    endtask
    task automatic wait_done(input logic [7:0] e);
        int k;
        for (k = 0; k < 3000 && cmd_done_out !== 1'b1; k++) @(negedge clk_sys_in);
        if (k == 3000) begin
            fails++;
            finish_test();
        end
        chk(40'(command_error_flags_out), 40'(e));
        chk(40'(command_completion_flags_out), 40'(st_exp(e)));
        tick();
    endtask
    // Stored words and pulse counts
    always @(negedge clk_sys_in) begin
        if (img_wr_out) begin
            chk({img_addr_out, img_data_out}, sb.size() ? sb.pop_front() : '1);
        end
        if (data_valid_in && data_ready_out) begin
            sb.push_back({wa, data_in});
            wa++;
        end
        disc_n += int'(discard_out);
        spin_n += int'(spin_down_out);
        rl_n += int'(reload_start_out);
    end
    initial begin
        tick(2);
        nrst_in = 1'b1;
        chk({32'h0, command_error_flags_out}, 40'h00);
        chk({32'h0, command_completion_flags_out}, 40'h50);
        // Reserved subcommands, then a valid one while locked
        for (int i = 0; i < 6; i++) begin
            f = i ? 8'(rnd()) : 8'h83;
            if (f == MDL_SUB_OFFSETS || f == MDL_SUB_WHOLE || i == 5) begin
                f = 8'(MDL_SUB_WHOLE * (i / 5));
            end
            security_locked_in = (i == 5);
            cmd(MDL_CMD_DOWNLOAD, f, 16'h0001, 16'h0000);
            wait_done(8'h04);
        end
        security_locked_in = 1'b0;
        cmd(8'h93, MDL_SUB_WHOLE, 16'h0001, 16'h0000);
        tick(3);
        chk(40'(data_ready_out), 40'h0);
        cmd(MDL_CMD_DOWNLOAD, MDL_SUB_WHOLE, 16'h0000, 16'h0000);
        wait_done(8'h00);
        // Whole image; cylinder bytes ignored
        lag = 4'(rnd());
        cmd(MDL_CMD_DOWNLOAD, MDL_SUB_WHOLE, 16'h0002, 16'h0005);
        tick();
        chk(40'(command_completion_flags_out), 40'h98);
        send(512);
        wait_done(8'h00);
        // Offset segments; the last reload fails
        image_sectors_in = 16'h0003;
        cmd(MDL_CMD_DOWNLOAD, MDL_SUB_OFFSETS, 16'h0001, 16'h0000);
        send(256);
        wait_done(8'h00);
        {reload_req_in, fail, d} = {2'b11, rl_n};
        cmd(MDL_CMD_DOWNLOAD, MDL_SUB_OFFSETS, 16'h0002, 16'h0001);
        send(512);
        wait_done(8'h40);
        chk(40'(rl_n - d), 40'h1);
        // Good reload with spin-up disabled
        {fail, spinup_disabled_in, d} = {2'b01, spin_n};
        cmd(MDL_CMD_DOWNLOAD, MDL_SUB_WHOLE, 16'h0001, 16'h0000);
        send(256);
        wait_done(8'h00);
        chk(40'(spin_n - d), 40'h1);
        // Verification refuses the image
        {reload_req_in, ok, d} = {2'b00, disc_n};
        cmd(MDL_CMD_DOWNLOAD, MDL_SUB_WHOLE, 16'h0001, 16'h0000);
        send(256);
        wait_done(8'h04);
        ok = 1'b1;
        // Gap in the offset sequence
        cmd(MDL_CMD_DOWNLOAD, MDL_SUB_OFFSETS, 16'h0001, 16'h0000);
        send(256);
        wait_done(8'h00);
        cmd(MDL_CMD_DOWNLOAD, MDL_SUB_OFFSETS, 16'h0001, 16'h0002);
        wait_done(8'h04);
        chk(40'(disc_n - d), 40'h2);
        // Foreign command in mid-transfer
        d = disc_n;
        cmd(MDL_CMD_DOWNLOAD, MDL_SUB_WHOLE, 16'h0001, 16'h0000);
        send(100);
        cmd(8'hec, 8'h00, 16'h0000, 16'h0000);
        tick(4);
        chk(40'(disc_n - d), 40'h1);
        // Soft reset with a segment pending, then a nonzero first offset
        cmd(MDL_CMD_DOWNLOAD, MDL_SUB_OFFSETS, 16'h0001, 16'h0000);
        send(256);
        wait_done(8'h00);
        soft_reset_in = 1'b1;
        tick();
        soft_reset_in = 1'b0;
        tick(3);
        chk(40'(disc_n - d), 40'h2);
        cmd(MDL_CMD_DOWNLOAD, MDL_SUB_OFFSETS, 16'h0001, 16'h0001);
        wait_done(8'h04);
        // Hardware reset in mid-transfer
        cmd(MDL_CMD_DOWNLOAD, MDL_SUB_WHOLE, 16'h0001, 16'h0000);
        send(50);
        nrst_in = 1'b0;
        tick();
        sb.delete();
        nrst_in = 1'b1;
        tick();
        chk({data_ready_out, command_error_flags_out, command_completion_flags_out}, 40'h50);
        finish_test();
    end
endmodule // mdl_download_cmd_tb_top
